// *** core/rcf_top.sv ***
// Added by the designer: the AXI4-Lite register port.
module rcf_top
  import rcf_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic [rcf_pkg::ADDR_W+1:0] s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [rcf_pkg::ADDR_W+1:0] s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 por_event,
  input  wire logic                 bor_event,
  input  wire logic                 watchdog_event,
  input  wire logic                 master_clear_pin_event,
  input  wire logic                 reset_instr_event,
  input  wire logic                 stack_ovf_event,
  input  wire logic                 stack_unf_event,
  input  wire logic                 memory_violation_flag_event,
  input  wire logic                 brownout_armed,
  output logic                      sw_brownout_enable,
  output logic                      irq
);
  import rcf_pkg::*;

  logic [8:0]        sync_lvl;
  logic [8:0]        sync_prev;
  logic [7:0]        ev;
  logic              power_ev;
  logic              brownout_ready;
  logic [7:0]        cause;
  logic              memory_violation_flag;
  logic [7:0]        irq_stat;
  logic [7:0]        irq_mask;
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_idx;
  logic [7:0]        wbyte;
  logic              wlane;
  logic [7:0]        next_cause;
  logic              next_memory_violation_flag;
  logic              next_sw_brownout_enable;
  logic [7:0]        next_irq_stat;
  logic [7:0]        next_irq_mask;
  logic              next_irq;
  logic              next_brdy;
  logic              next_aw_full;
  logic              next_w_full;
  logic [ADDR_W-1:0] next_aw_idx;
  logic [7:0]        next_wbyte;
  logic              next_wlane;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_awready;
  logic              next_wready;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              wr_go;

  rcf_sync #(
    .WIDTH (9)
  ) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({brownout_armed, stack_ovf_event, stack_unf_event, memory_violation_flag_event,
                watchdog_event, master_clear_pin_event, reset_instr_event,
                por_event, bor_event}),
    .sync_out (sync_lvl)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_prev <= 9'h000;
    end else begin
      sync_prev <= sync_lvl;
    end
  end

  // Rising edge of each synced cause, laid out like the cause register
  assign ev       = sync_lvl[7:0] & ~sync_prev[7:0];
  assign power_ev = ev[BIT_POR] | ev[BIT_BOR];

  function automatic logic is_mapped(input logic [ADDR_W-1:0] idx);
    if (idx == IDX_BORCTL) begin
      return 1'b1;
    end else if (idx == IDX_CAUSE || idx == IDX_MEMORY_VIOLATION_FLAG) begin
      return 1'b1;
    end else if (idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // Register readback, reserved bits read zero
  function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] idx);
    if (idx == IDX_BORCTL) begin
      return {sw_brownout_enable, 6'h00, brownout_ready};
    end else if (idx == IDX_CAUSE) begin
      return cause & CAUSE_MASK;
    end else if (idx == IDX_MEMORY_VIOLATION_FLAG) begin
      return {6'h00, memory_violation_flag, 1'b0};
    end else if (idx == IDX_IRQ_STAT) begin
      return irq_stat;
    end else if (idx == IDX_IRQ_MASK) begin
      return irq_mask;
    end else begin
      return 8'h00;
    end
  endfunction

  // Bus slave
  assign wr_go = aw_full && w_full && !s_axi_bvalid;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_idx  = aw_idx;
    next_wbyte   = wbyte;
    next_wlane   = wlane;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_idx  = s_axi_awaddr[ADDR_W+1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_wbyte  = s_axi_wdata[7:0];
      next_wlane  = s_axi_wstrb[0];
    end
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {24'h000000, read_reg(s_axi_araddr[ADDR_W+1:2])};
      next_rresp  = is_mapped(s_axi_araddr[ADDR_W+1:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_idx        <= '0;
      wbyte         <= 8'h00;
      wlane         <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      aw_idx        <= next_aw_idx;
      wbyte         <= next_wbyte;
      wlane         <= next_wlane;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
    end
  end

  // Flag bank: firmware first, hardware causes override
  always_comb begin
    next_cause    = cause;
    next_memory_violation_flag     = memory_violation_flag;
    next_sw_brownout_enable   = sw_brownout_enable;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat | ev;
    next_brdy     = sync_lvl[8];
    if (wr_go && wlane) begin
      if (aw_idx == IDX_BORCTL) begin
        next_sw_brownout_enable = wbyte[BIT_SW_BROWNOUT_ENABLE];
      end else if (aw_idx == IDX_CAUSE) begin
        next_cause = wbyte & CAUSE_MASK;
      end else if (aw_idx == IDX_MEMORY_VIOLATION_FLAG) begin
        next_memory_violation_flag = wbyte[BIT_MEMORY_VIOLATION_FLAG];
      end else if (aw_idx == IDX_IRQ_STAT) begin
        next_irq_stat = (irq_stat & ~wbyte) | ev;
      end else if (aw_idx == IDX_IRQ_MASK) begin
        next_irq_mask = wbyte;
      end
    end
    if (power_ev) begin
      next_cause[BIT_STACK_OVERFLOW_FLAG] = 1'b0;
      next_cause[BIT_STACK_UNDERFLOW_FLAG] = 1'b0;
      next_cause[BIT_WDT]    = 1'b1;
      next_cause[BIT_PIN]    = 1'b1;
      next_cause[BIT_RI]     = 1'b1;
      next_memory_violation_flag              = 1'b1;
      next_sw_brownout_enable            = SW_BROWNOUT_ENABLE_RST;
      if (ev[BIT_POR]) begin
        next_cause[BIT_POR] = 1'b0;
        next_cause[BIT_BOR] = 1'b1;
      end
      if (ev[BIT_BOR]) begin
        next_cause[BIT_BOR] = 1'b0;
      end
    end else begin
      // Only the firing cause moves
      if (ev[BIT_STACK_OVERFLOW_FLAG]) begin
        next_cause[BIT_STACK_OVERFLOW_FLAG] = 1'b1;
      end
      if (ev[BIT_STACK_UNDERFLOW_FLAG]) begin
        next_cause[BIT_STACK_UNDERFLOW_FLAG] = 1'b1;
      end
      if (ev[BIT_WDT]) begin
        next_cause[BIT_WDT] = 1'b0;
      end
      if (ev[BIT_PIN]) begin
        next_cause[BIT_PIN] = 1'b0;
      end
      if (ev[BIT_RI]) begin
        next_cause[BIT_RI] = 1'b0;
      end
      if (ev[BIT_EVMEMV]) begin
        next_memory_violation_flag = 1'b0;
      end
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cause                 <= CAUSE_RST;
      memory_violation_flag <= MEMORY_VIOLATION_FLAG_RST;
      sw_brownout_enable    <= SW_BROWNOUT_ENABLE_RST;
      irq_stat              <= 8'h00;
      irq_mask              <= IRQ_MASK_RST;
      brownout_ready        <= 1'b0;
      irq                   <= 1'b0;
    end else begin
      cause                 <= next_cause;
      memory_violation_flag <= next_memory_violation_flag;
      sw_brownout_enable    <= next_sw_brownout_enable;
      irq_stat              <= next_irq_stat;
      irq_mask              <= next_irq_mask;
      brownout_ready        <= next_brdy;
      irq                   <= next_irq;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_nonpower_ev(int b);
    ev[b] && !power_ev;
  endsequence

  property p_ready;
    sync_lvl[8] ##1 sync_lvl[8] |-> brownout_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit not following detector");

  property p_ovf;
    s_nonpower_ev(BIT_STACK_OVERFLOW_FLAG) |=> cause[BIT_STACK_OVERFLOW_FLAG];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");

  property p_unf;
    s_nonpower_ev(BIT_STACK_UNDERFLOW_FLAG) |=> cause[BIT_STACK_UNDERFLOW_FLAG];
  endproperty
  a_unf: assert property (p_unf) else $error("underflow flag not set");

  property p_wdt;
    s_nonpower_ev(BIT_WDT) |=> !cause[BIT_WDT] && $stable(cause[BIT_PIN]);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog flag not cleared");

  property p_pin;
    s_nonpower_ev(BIT_PIN) |=> !cause[BIT_PIN];
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset flag not cleared");

  property p_ri;
    s_nonpower_ev(BIT_RI) |=> !cause[BIT_RI];
  endproperty
  a_ri: assert property (p_ri) else $error("instruction flag not cleared");

  property p_por;
    ev[BIT_POR] |=> !cause[BIT_POR] && cause[BIT_WDT] && cause[BIT_PIN] && cause[BIT_RI];
  endproperty
  a_por: assert property (p_por) else $error("power-on values wrong");

  property p_bor;
    ev[BIT_BOR] && !ev[BIT_POR] |=> !cause[BIT_BOR] && cause[BIT_POR] == $past(cause[BIT_POR]);
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out values wrong");

  property p_memory_violation_flag;
    s_nonpower_ev(BIT_EVMEMV) |=>
      !memory_violation_flag ##1 ($stable(memory_violation_flag) || $past(wr_go));
  endproperty
  a_memory_violation_flag: assert property (p_memory_violation_flag) else $error("violation flag wrong");

  property p_stack_power;
    power_ev |=> cause[BIT_STACK_OVERFLOW_FLAG:BIT_STACK_UNDERFLOW_FLAG] == 2'b00 && memory_violation_flag;
  endproperty
  a_stack_power: assert property (p_stack_power) else $error("stack flags not cleared");

  property p_quiet;
    ev == 8'h00 && !wr_go |=> $stable(cause) && $stable(memory_violation_flag);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag moved without cause");

  property p_hw_wins;
    s_nonpower_ev(BIT_WDT) and (wr_go && wlane && aw_idx == IDX_CAUSE) |=> !cause[BIT_WDT];
  endproperty
  a_hw_wins: assert property (p_hw_wins) else $error("write beat hardware update");

  property p_write_store;
    wr_go && wlane && aw_idx == IDX_CAUSE && ev == 8'h00 |=> cause == (wbyte & CAUSE_MASK);
  endproperty
  a_write_store: assert property (p_write_store) else $error("firmware write not stored");
endmodule

// *** core/rcf_pkg.sv ***
package rcf_pkg;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] IDX_BORCTL    = 12'h18d;
  localparam logic [11:0] IDX_CAUSE     = 12'h18e;
  localparam logic [11:0] IDX_MEMORY_VIOLATION_FLAG      = 12'h18f;
  localparam logic [11:0] IDX_IRQ_STAT  = 12'h190;
  localparam logic [11:0] IDX_IRQ_MASK  = 12'h191;
  localparam int          BIT_BRDY      = 0;
  localparam int          BIT_SW_BROWNOUT_ENABLE    = 7;
  localparam int          BIT_STACK_OVERFLOW_FLAG    = 7;
  localparam int          BIT_STACK_UNDERFLOW_FLAG    = 6;
  localparam int          BIT_EVMEMV    = 5;
  localparam int          BIT_WDT       = 4;
  localparam int          BIT_PIN       = 3;
  localparam int          BIT_RI        = 2;
  localparam int          BIT_POR       = 1;
  localparam int          BIT_BOR       = 0;
  localparam int          BIT_MEMORY_VIOLATION_FLAG      = 1;
  localparam logic [7:0]  CAUSE_MASK    = 8'hdf;
  localparam logic [7:0]  CAUSE_RST     = 8'h1d;
  localparam logic        MEMORY_VIOLATION_FLAG_RST      = 1'b1;
  localparam logic        SW_BROWNOUT_ENABLE_RST    = 1'b1;
  localparam logic [7:0]  IRQ_MASK_RST  = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage

// *** core/rcf_sync.sv ***
module rcf_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Two flops per bit, first stage read by second only
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (reset) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end
endmodule

// *** tb/rcf_top_tb_top.sv ***
module rcf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcf_pkg::*;

  localparam int LIMIT = 20000;

  logic                   mclk;
  logic                   reset;
  logic [ADDR_W+1:0]      s_axi_awaddr;
  logic                   s_axi_awvalid;
  logic                   s_axi_awready;
  logic [31:0]            s_axi_wdata;
  logic [3:0]             s_axi_wstrb;
  logic                   s_axi_wvalid;
  logic                   s_axi_wready;
  logic [1:0]             s_axi_bresp;
  logic                   s_axi_bvalid;
  logic                   s_axi_bready;
  logic [ADDR_W+1:0]      s_axi_araddr;
  logic                   s_axi_arvalid;
  logic                   s_axi_arready;
  logic [31:0]            s_axi_rdata;
  logic [1:0]             s_axi_rresp;
  logic                   s_axi_rvalid;
  logic                   s_axi_rready;
  logic [7:0]             ev;
  logic                   brownout_armed;
  logic                   sw_brownout_enable;
  logic                   irq;
  int                     n_mismatch;
  int                     checked;
  int                     cyc;
  logic [7:0]             ec;
  logic                   em;

  rcf_top u_rcf_top (
    .mclk                   (mclk),
    .reset                  (reset),
    .s_axi_awaddr           (s_axi_awaddr),
    .s_axi_awvalid          (s_axi_awvalid),
    .s_axi_awready          (s_axi_awready),
    .s_axi_wdata            (s_axi_wdata),
    .s_axi_wstrb            (s_axi_wstrb),
    .s_axi_wvalid           (s_axi_wvalid),
    .s_axi_wready           (s_axi_wready),
    .s_axi_bresp            (s_axi_bresp),
    .s_axi_bvalid           (s_axi_bvalid),
    .s_axi_bready           (s_axi_bready),
    .s_axi_araddr           (s_axi_araddr),
    .s_axi_arvalid          (s_axi_arvalid),
    .s_axi_arready          (s_axi_arready),
    .s_axi_rdata            (s_axi_rdata),
    .s_axi_rresp            (s_axi_rresp),
    .s_axi_rvalid           (s_axi_rvalid),
    .s_axi_rready           (s_axi_rready),
    .por_event              (ev[1]),
    .bor_event              (ev[0]),
    .watchdog_event         (ev[4]),
    .master_clear_pin_event (ev[3]),
    .reset_instr_event      (ev[2]),
    .stack_ovf_event        (ev[7]),
    .stack_unf_event        (ev[6]),
    .memory_violation_flag_event             (ev[5]),
    .brownout_armed         (brownout_armed),
    .sw_brownout_enable     (sw_brownout_enable),
    .irq                    (irq)
  );

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] exp_resp);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= st;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, exp_resp}, "write response");
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp,
                        input logic [1:0] exp_resp);
    @(posedge mclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge mclk);
    chk(s_axi_rdata, {24'h000000, exp}, "read data");
    chk({30'h0, s_axi_rresp}, {30'h0, exp_resp}, "read response");
    s_axi_rready <= 1'b0;
  endtask

  task automatic fire(input int b);
    @(posedge mclk);
    ev[b] <= 1'b1;
    repeat (4) @(posedge mclk);
    ev[b] <= 1'b0;
    repeat (4) @(posedge mclk);
    case (b)
      7, 6:    ec[b] = 1'b1;
      5:       em = 1'b0;
      4, 3, 2: ec[b] = 1'b0;
      1: begin
        ec = 8'h1d;
        em = 1'b1;
      end
      default: begin
        ec = {3'b000, 3'b111, ec[1], 1'b0};
        em = 1'b1;
      end
    endcase
  endtask

  task automatic t_reset_values();
    rd_chk(IDX_BORCTL, 8'h80, RESP_OKAY);
    rd_chk(IDX_CAUSE, 8'h1d, RESP_OKAY);
    rd_chk(IDX_MEMORY_VIOLATION_FLAG, 8'h02, RESP_OKAY);
    rd_chk(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test reset_values done");
  endtask

  task automatic t_events();
    int seq [9] = '{4, 3, 2, 7, 6, 5, 0, 5, 1};
    foreach (seq[i]) begin
      fire(seq[i]);
      rd_chk(IDX_CAUSE, ec, RESP_OKAY);
      rd_chk(IDX_MEMORY_VIOLATION_FLAG, {6'h00, em, 1'b0}, RESP_OKAY);
    end
    $display("test events done");
  endtask

  task automatic t_fw_writes();
    wr(IDX_CAUSE, 8'hff, 4'h1, RESP_OKAY);
    rd_chk(IDX_CAUSE, 8'hdf, RESP_OKAY);
    rd_chk(IDX_MEMORY_VIOLATION_FLAG, 8'h02, RESP_OKAY);
    wr(IDX_CAUSE, 8'h00, 4'h1, RESP_OKAY);
    rd_chk(IDX_CAUSE, 8'h00, RESP_OKAY);
    wr(IDX_CAUSE, 8'hff, 4'h0, RESP_OKAY);
    rd_chk(IDX_CAUSE, 8'h00, RESP_OKAY);
    fire(5);
    rd_chk(IDX_MEMORY_VIOLATION_FLAG, 8'h00, RESP_OKAY);
    wr(IDX_MEMORY_VIOLATION_FLAG, 8'h02, 4'h1, RESP_OKAY);
    rd_chk(IDX_MEMORY_VIOLATION_FLAG, 8'h02, RESP_OKAY);
    fire(5);
    rd_chk(IDX_MEMORY_VIOLATION_FLAG, 8'h00, RESP_OKAY);
    chk({31'h0, sw_brownout_enable}, 32'h1, "enable kept");
    $display("test fw_writes done");
  endtask

  task automatic t_brownout();
    wr(IDX_BORCTL, 8'h00, 4'h1, RESP_OKAY);
    chk({31'h0, sw_brownout_enable}, 32'h0, "enable cleared");
    rd_chk(IDX_BORCTL, 8'h00, RESP_OKAY);
    brownout_armed <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk(IDX_BORCTL, 8'h01, RESP_OKAY);
    wr(IDX_BORCTL, 8'h80, 4'h1, RESP_OKAY);
    rd_chk(IDX_BORCTL, 8'h81, RESP_OKAY);
    brownout_armed <= 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(IDX_BORCTL, 8'h80, RESP_OKAY);
    $display("test brownout done");
  endtask

  task automatic t_map_and_irq();
    wr(12'h192, 8'h55, 4'h1, RESP_SLVERR);
    rd_chk(12'h18c, 8'h00, RESP_SLVERR);
    wr(IDX_CAUSE, 8'h1d, 4'h1, RESP_OKAY);
    ec = 8'h1d;
    wr(IDX_IRQ_STAT, 8'hff, 4'h1, RESP_OKAY);
    rd_chk(IDX_IRQ_STAT, 8'h00, RESP_OKAY);
    fire(4);
    rd_chk(IDX_IRQ_STAT, 8'h10, RESP_OKAY);
    rd_chk(IDX_CAUSE, ec, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(IDX_IRQ_MASK, 8'h10, 4'h1, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(IDX_IRQ_STAT, 8'h10, 4'h1, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd_chk(IDX_IRQ_STAT, 8'h00, RESP_OKAY);
    $display("test map_and_irq done");
  endtask

  // Watchdog edge lands in the same cycle as the cause write commit
  task automatic t_hw_wins();
    @(posedge mclk);
    ev[4] <= 1'b1;
    wr(IDX_CAUSE, 8'hff, 4'h1, RESP_OKAY);
    ev[4] <= 1'b0;
    rd_chk(IDX_CAUSE, 8'hcf, RESP_OKAY);
    $display("test hw_wins done");
  endtask

  initial begin
    reset          = 1'b1;
    s_axi_awaddr   = '0;
    s_axi_awvalid  = 1'b0;
    s_axi_wdata    = '0;
    s_axi_wstrb    = '0;
    s_axi_wvalid   = 1'b0;
    s_axi_bready   = 1'b0;
    s_axi_araddr   = '0;
    s_axi_arvalid  = 1'b0;
    s_axi_rready   = 1'b0;
    ev             = 8'h00;
    brownout_armed = 1'b0;
    n_mismatch     = 0;
    checked        = 0;
    cyc            = 0;
    ec             = 8'h1d;
    em             = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    t_reset_values();
    t_events();
    t_fw_writes();
    t_brownout();
    t_map_and_irq();
    t_hw_wins();
    close_out();
  end
endmodule
